// File: src/return_and_rotate_exec.sv
// Execution of the return, literal-return and rotate-through-carry instructions.
`timescale 1ns/1ps
`include "exec_consts.svh"

module return_and_rotate_exec
  import exec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic        carry_in,
  input  wire logic [12:0] stack_top_entry,
  output byte_write_t      acc_write,
  output reg_write_t       file_write,
  output logic             carry_write,
  output logic             carry_out,
  output logic             stack_pop,
  output logic             pc_load,
  output logic [12:0]      pc_value,
  output logic             busy
);

  // Register data arrives combinationally for the addressed register of the current instruction.
  function automatic logic [8:0] rotate9(input logic left, input logic [7:0] v, input logic c);
    rotate9 = left ? {v[7], v[6:0], c} : {v[0], c, v[7:1]};
  endfunction : rotate9

  // The state machine serves exactly one flush cycle behind a return and none behind a rotate.
  if (`RETURN_CYCLES != 2 || `ROTATE_CYCLES != 1 || `DEST_BIT > 13)
  begin : g_cycle_check
    $error("cycle counts or field positions do not fit the executor");
  end

  exec_state_t state;
  exec_state_t next_state;
  byte_write_t next_acc_write;
  reg_write_t  next_file_write;
  logic        next_carry_write;
  logic        next_carry_out;
  logic        next_stack_pop;
  logic        next_pc_load;
  logic [12:0] next_pc_value;
  logic        next_busy;
  logic        is_ret;
  logic        is_retlit;
  logic        is_rotr;
  logic        is_rotl;
  logic [8:0]  rot;

  always_comb
  begin
    is_ret    = instr_valid && instr == `OP_RETURN;
    is_retlit = instr_valid && instr[13:10] == `OP_RETLIT_HI;
    is_rotr   = instr_valid && instr[13:8] == `OP_ROT_RIGHT_HI;
    is_rotl   = instr_valid && instr[13:8] == `OP_ROT_LEFT_HI;
    rot       = rotate9(is_rotl, reg_rdata, carry_in);
    next_state       = EXEC_IDLE;
    next_acc_write   = '0;
    next_file_write  = '0;
    next_carry_write = 1'b0;
    // Carry and pc values hold between updates, so flag and fetch logic may sample them at any time.
    next_carry_out   = carry_out;
    next_stack_pop   = 1'b0;
    next_pc_load     = 1'b0;
    next_pc_value    = pc_value;
    next_busy        = 1'b0;
    case (state)
      EXEC_IDLE:
      begin
        if (is_ret || is_retlit)
        begin
          // The second cycle flushes the fetched word; no flag is touched.
          next_stack_pop = 1'b1;
          next_pc_load   = 1'b1;
          next_pc_value  = stack_top_entry;
          next_busy      = 1'b1;
          next_state     = EXEC_FLUSH;
          if (is_retlit)
          begin
            next_acc_write.en   = 1'b1;
            next_acc_write.data = instr[7:0];
          end
        end
        else if (is_rotr || is_rotl)
        begin
          next_carry_write = 1'b1;
          next_carry_out   = rot[8];
          if (instr[`DEST_BIT])
          begin
            next_file_write.en   = 1'b1;
            next_file_write.addr = instr[6:0];
            next_file_write.data = rot[7:0];
          end
          else
          begin
            next_acc_write.en   = 1'b1;
            next_acc_write.data = rot[7:0];
          end
        end
      end
      // The word fetched behind a return is discarded here.
      EXEC_FLUSH:
        next_state = EXEC_IDLE;
      default:
        next_state = EXEC_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state       <= EXEC_IDLE;
      acc_write   <= '0;
      file_write  <= '0;
      carry_write <= 1'b0;
      carry_out   <= 1'b0;
      stack_pop   <= 1'b0;
      pc_load     <= 1'b0;
      pc_value    <= `PC_VALUE_RESET;
      busy        <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      acc_write   <= next_acc_write;
      file_write  <= next_file_write;
      carry_write <= next_carry_write;
      carry_out   <= next_carry_out;
      stack_pop   <= next_stack_pop;
      pc_load     <= next_pc_load;
      pc_value    <= next_pc_value;
      busy        <= next_busy;
    end
  end

  // The taken sequences start from a word that the idle state takes; words offered during the flush are refused.
  sequence s_return_taken;
    state == EXEC_IDLE && instr_valid && (instr == `OP_RETURN || instr[13:10] == `OP_RETLIT_HI);
  endsequence

  sequence s_return_done;
    pc_load && stack_pop && !carry_write ##1 !pc_load && state == EXEC_IDLE;
  endsequence

  sequence s_rotate_taken;
    state == EXEC_IDLE && instr_valid && instr[13:9] == 5'h06;
  endsequence

  a_return_pops_pc: assert property (@(posedge clk) disable iff (rst)
    s_return_taken |=> s_return_done)
    else $error("return did not pop stack into pc over two cycles");

  a_retlit_loads_acc: assert property (@(posedge clk) disable iff (rst)
    state == EXEC_IDLE && instr_valid && instr[13:10] == `OP_RETLIT_HI
    |=> acc_write.en && acc_write.data == $past(instr[7:0]))
    else $error("literal return did not load accumulator");

  a_retlit_two_cycles: assert property (@(posedge clk) disable iff (rst)
    pc_load |-> busy && !carry_write ##1 (!pc_load && !busy))
    else $error("return did not take exactly two cycles");

  a_pc_from_stack: assert property (@(posedge clk) disable iff (rst)
    s_return_taken |=> pc_value == $past(stack_top_entry))
    else $error("pc not loaded from stack top");

  a_rotr_value: assert property (@(posedge clk) disable iff (rst)
    state == EXEC_IDLE && instr_valid && instr[13:8] == `OP_ROT_RIGHT_HI
    |=> carry_write && carry_out == $past(reg_rdata[0])
        && (acc_write.en ? acc_write.data : file_write.data) == {$past(carry_in), $past(reg_rdata[7:1])})
    else $error("right rotate result wrong");

  a_rotl_value: assert property (@(posedge clk) disable iff (rst)
    state == EXEC_IDLE && instr_valid && instr[13:8] == `OP_ROT_LEFT_HI
    |=> carry_write && carry_out == $past(reg_rdata[7]) && !pc_load
        && (acc_write.en ? acc_write.data : file_write.data) == {$past(reg_rdata[6:0]), $past(carry_in)})
    else $error("left rotate result wrong");

  a_rot_dest_select: assert property (@(posedge clk) disable iff (rst)
    state == EXEC_IDLE && instr_valid && instr[13:9] == 5'h06
    |=> (file_write.en == $past(instr[`DEST_BIT])) && (acc_write.en != $past(instr[`DEST_BIT]))
        && file_write.addr == ($past(instr[`DEST_BIT]) ? $past(instr[6:0]) : 7'h00))
    else $error("rotate destination select wrong");

  a_carry_only_rot: assert property (@(posedge clk) disable iff (rst)
    carry_write |-> !pc_load && !stack_pop && !busy)
    else $error("carry changed outside a rotate");

  a_rotate_one_cycle: assert property (@(posedge clk) disable iff (rst)
    s_rotate_taken |=> carry_write && !busy && state == EXEC_IDLE)
    else $error("rotate did not finish in one cycle");

  a_flush_drops_instr: assert property (@(posedge clk) disable iff (rst)
    state == EXEC_FLUSH |=> !carry_write && !acc_write.en && !file_write.en && !pc_load && !stack_pop)
    else $error("instruction taken during return flush");

  a_carry_holds: assert property (@(posedge clk) disable iff (rst)
    !carry_write |-> $stable(carry_out))
    else $error("carry value moved without a rotate");

  a_pc_holds: assert property (@(posedge clk) disable iff (rst)
    !pc_load |-> $stable(pc_value))
    else $error("pc value moved without a return");

  a_return_no_write: assert property (@(posedge clk) disable iff (rst)
    state == EXEC_IDLE && instr_valid && instr == `OP_RETURN |=> !acc_write.en && !file_write.en)
    else $error("plain return wrote a register");

  a_pop_with_load: assert property (@(posedge clk) disable iff (rst)
    stack_pop == pc_load)
    else $error("stack pop and pc load out of step");

  a_one_dest: assert property (@(posedge clk) disable iff (rst)
    !(acc_write.en && file_write.en))
    else $error("rotate result sent to both destinations");

endmodule : return_and_rotate_exec

// File: include/exec_consts.svh
// Opcode patterns, field positions and cycle counts for the return and rotate executor.
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH
`define OP_RETURN       14'h0008
`define OP_RETLIT_HI    4'h0D
`define OP_ROT_RIGHT_HI 6'h0C
`define OP_ROT_LEFT_HI  6'h0D
`define DEST_BIT        7
`define RETURN_CYCLES   2
`define ROTATE_CYCLES   1
`define STATUS_CARRY    0
`define PC_VALUE_RESET  13'h0000
`endif

// File: include/exec_pkg.sv
// Types shared by the return and rotate executor.
package exec_pkg;
  typedef struct packed {
    logic       en;
    logic [7:0] data;
  } byte_write_t;

  typedef struct packed {
    logic       en;
    logic [6:0] addr;
    logic [7:0] data;
  } reg_write_t;

  typedef enum logic [1:0] {
    EXEC_IDLE,
    EXEC_FLUSH
  } exec_state_t;
endpackage : exec_pkg

// File: bench/return_and_rotate_exec_bench.sv
// Self-checking bench for the return and rotate executor.
`timescale 1ns/1ps
module return_and_rotate_exec_bench
  import exec_pkg::*;
;
  logic        clk, rst, instr_valid, carry_in;
  logic [13:0] instr;
  logic [7:0]  reg_rdata;
  logic [12:0] stack_top_entry, pc_value;
  byte_write_t acc_write;
  reg_write_t  file_write;
  logic        carry_write, carry_out, stack_pop, pc_load, busy;
  int          err_count, checked, cycles;

  return_and_rotate_exec i_return_and_rotate_exec (.clk, .rst, .instr_valid, .instr, .reg_rdata, .carry_in,
    .stack_top_entry, .acc_write, .file_write, .carry_write, .carry_out, .stack_pop, .pc_load, .pc_value, .busy);

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task conclude;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task t_return;
    @(negedge clk);
    instr = 14'h0008;
    instr_valid = 1'b1;
    @(negedge clk);
    chk("pop_load_busy", 3'b111, {stack_pop, pc_load, busy});
    chk("pc", 16'h1abc, pc_value);
    chk("acc_carry", 2'b00, {acc_write.en, carry_write});
    // A rotate offered while the flush runs must be dropped.
    instr = 14'h0d85;
    @(negedge clk);
    chk("second_cycle", 4'b0000, {pc_load, busy, carry_write, file_write.en});
    instr_valid = 1'b0;
  endtask : t_return

  task t_ignored;
    @(negedge clk);
    instr = 14'h0009;
    instr_valid = 1'b1;
    @(negedge clk);
    instr = 14'h0e55;
    chk("other_a", 5'b00000, {acc_write.en, file_write.en, carry_write, pc_load, stack_pop});
    @(negedge clk);
    instr_valid = 1'b0;
    chk("other_b", 5'b00000, {acc_write.en, file_write.en, carry_write, pc_load, stack_pop});
  endtask : t_ignored

  task t_retlit(input logic [7:0] k);
    @(negedge clk);
    instr = {4'hd, 2'b10, k};
    stack_top_entry = {5'h15, k};
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    chk("acc", {1'b1, k}, acc_write);
    chk("pop_load_carry", 3'b110, {stack_pop, pc_load, carry_write});
    chk("pc", {3'b000, 5'h15, k}, pc_value);
    chk("busy", 1'b1, busy);
    @(negedge clk);
    chk("retlit_end", 3'b000, {pc_load, busy, acc_write.en});
  endtask : t_retlit

  task t_rot_burst;
    @(negedge clk);
    instr = {6'h0c, 1'b1, 7'h2a};
    reg_rdata = 8'h81;
    carry_in = 1'b0;
    instr_valid = 1'b1;
    @(negedge clk);
    instr = {6'h0d, 1'b0, 7'h2a};
    reg_rdata = 8'h42;
    carry_in = 1'b1;
    chk("burst_right", {1'b1, 7'h2a, 8'h40}, {carry_out, file_write.addr, file_write.data});
    @(negedge clk);
    instr_valid = 1'b0;
    chk("burst_left", {2'b10, 1'b1, 8'h85}, {carry_write, carry_out, acc_write});
  endtask : t_rot_burst

  task t_rot(input logic left, input logic d, input logic [7:0] rd, input logic cin);
    logic [7:0] res;
    res = left ? {rd[6:0], cin} : {cin, rd[7:1]};
    @(negedge clk);
    instr = {left ? 6'h0d : 6'h0c, d, 7'h55};
    reg_rdata = rd;
    carry_in = cin;
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    chk("carry", {1'b1, left ? rd[7] : rd[0]}, {carry_write, carry_out});
    chk("no_branch", 2'b00, {pc_load, stack_pop});
    chk("acc_en", !d, acc_write.en);
    chk("file_en", d, file_write.en);
    if (d)
      chk("file", {7'h55, res}, {file_write.addr, file_write.data});
    else
      chk("acc_data", res, acc_write.data);
  endtask : t_rot

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      conclude();
    end
  end

  initial
  begin
    rst = 1'b1;
    instr_valid = 1'b0;
    carry_in = 1'b0;
    instr = 14'h0000;
    reg_rdata = 8'h00;
    stack_top_entry = 13'h1abc;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk("reset", 3'b000, {pc_load, acc_write.en, carry_write});
    t_ignored();
    t_return();
    t_retlit(8'hff);
    t_retlit(8'h00);
    for (int i = 0; i < 8; i++)
      t_rot(i[2], i[1], {~i[0], 6'h19, ~i[0]}, i[0]);
    t_rot_burst();
    conclude();
  end
endmodule : return_and_rotate_exec_bench
